// ===== logic/psc_pkg.sv
package psc_pkg;
   localparam logic [6:0]  SLAVE_ADDR     = 7'h38;
   localparam logic [7:0]  CMD_MEASURE    = 8'hAC;
   localparam logic [7:0]  CMD_ONDEMAND   = 8'hA8;
   localparam logic [7:0]  CMD_PERIODIC   = 8'hE0;
   localparam logic [7:0]  CMD_CONFIG     = 8'hE1;
   localparam logic [7:0]  CMD_SOFT_RESET = 8'hBA;
   localparam logic [7:0]  CMD_FIFO_RESET = 8'hBB;
   localparam int          CFG_INT_LEVEL  = 15;
   localparam int          CFG_FULL_IRQ   = 14;
   localparam int          CFG_FIFO_ON    = 12;
   localparam int          CFG_CALIB      = 11;
   localparam int          CFG_TRATE_LSB  = 6;
   localparam int          CFG_CYCLE_LSB  = 3;
   localparam logic [15:0] CFG_WRITABLE   = 16'hD9F8;
   localparam logic [15:0] CFG_RESET      = 16'h9800;
   localparam logic [7:0]  OSR_RESET      = 8'h77;
   localparam int          TEMPERATURE_OVERSAMPLE_CODE_LSB      = 4;
   localparam int          PRESSURE_OVERSAMPLE_CODE_LSB      = 0;
   localparam int          ST_BUSY        = 7;
   localparam int          CLK_PERIOD_NS  = 20;
   // one tick is 0.1 ms; all durations below count ticks
   localparam int          TICK_NS        = 100000;
   typedef logic [13:0] psc_ticks_type;
   localparam psc_ticks_type MEAS_TICKS [0:7] = '{14'h14A, 14'h0AA, 14'h054, 14'h02B,
                                                 14'h016, 14'h00C, 14'h007, 14'h004};
   localparam psc_ticks_type CYCLE_TICKS [0:7] = '{14'h0032, 14'h0064, 14'h00C8, 14'h0190,
                                                  14'h0320, 14'h09C4, 14'h1388, 14'h2710};
endpackage

// ===== logic/psc_core.sv
// How it works
// - measurement start drives the done pin to its inactive level
// - measurement completion drives the done pin to its active level
// - reading a measurement word returns the done pin to inactive
// - after every measurement the engine returns to sleep until new work
// - 0xAC with oversampling starts one measurement giving pressure and temperature
// - status busy bit: 1 while measuring, 0 when finished
// - decode 0xA8 on-demand, 0xE0 periodic, 0xE1 config, 0xBA soft reset, 0xBB fifo reset
// - config bits 5:3 pick cycle period 5 ms up to 1000 ms
// - config bit 15 picks done pin polarity, 1 is active high
// - config bit 14 lets a full fifo raise the done pin
// - config bit 12 switches the result fifo on in periodic mode
// - config bit 11 picks calibrated data, 0 picks raw converter data
// - config bits 8:6 measure temperature every 2^n cycles
// - each 3-bit oversampling code (pressure, temperature) adds duration, 33 ms at 000 to 0.4 ms at 111
// - each reading is 24 bits, value in the upper 20
// - calibrated temperature code is fraction of -50..150 C full scale
// - a command arriving mid-measurement waits; later ones are dropped
// - every read starts with the status byte
// - on-demand mode after power-on, sleeping unless commanded
// - status bit 7 reads 1 while measuring, 0 when asleep
`timescale 1ns/100ps
module psc_core #(
   parameter int TICK_CYCLES = psc_pkg::TICK_NS / psc_pkg::CLK_PERIOD_NS
) (
   input  wire logic        clk_sys_i,
   input  wire logic        nrst_i,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_o,
   output logic             int_o,
   input  wire logic [19:0] raw_press_i,
   input  wire logic [19:0] cal_press_i,
   input  wire logic [19:0] raw_temp_i,
   input  wire logic [19:0] cal_temp_i
);
   typedef enum logic [3:0] {I_IDLE = 4'h1, I_ADDR = 4'h2, I_WR = 4'h4, I_RD = 4'h8} psc_bus_type;
   typedef enum logic [1:0] {M_SLEEP = 2'h1, M_MEAS = 2'h2} psc_meas_type;

   psc_bus_type  i_state;
   psc_meas_type m_state;
   logic [1:0]   scl_sync;
   logic [1:0]   sda_sync;
   logic         scl_prev;
   logic         sda_prev;
   logic [15:0]  tick_cnt;
   logic [3:0]   bit_cnt;
   logic [7:0]   shreg;
   logic [7:0]   tx;
   logic         m_ack;
   logic [1:0]   wr_cnt;
   logic [7:0]   cmd_b;
   logic [7:0]   d0_b;
   logic [7:0]   d1_b;
   logic [2:0]   rd_seq;
   logic         pend_valid;
   logic [7:0]   pend_cmd;
   logic [7:0]   pend_d0;
   logic [7:0]   pend_d1;
   logic [15:0]  cfg;
   logic [7:0]   osr;
   logic         periodic;
   logic         cyc_due;
   logic         done_flag;
   logic [13:0]  timer;
   logic [13:0]  period;
   logic [6:0]   temp_seq;
   logic [23:0]  press_word;
   logic [23:0]  temp_word;
   logic [23:0]  buf_mem [0:1];
   logic         wr_ptr;
   logic         rd_ptr;
   logic [1:0]   buf_cnt;

   // synchronised bus pins; only the second stage is looked at
   wire scl_s      = scl_sync[1];
   wire sda_s      = sda_sync[1];
   wire scl_rise   = scl_s & ~scl_prev;
   wire scl_fall   = ~scl_s & scl_prev;
   wire start_cond = scl_s & scl_prev & sda_prev & ~sda_s;
   wire stop_cond  = scl_s & scl_prev & ~sda_prev & sda_s;
   wire tick       = tick_cnt == 16'(TICK_CYCLES - 1);
   wire addr_hit   = shreg[7:1] == psc_pkg::SLAVE_ADDR;
   wire slot_end   = scl_fall & (bit_cnt == 4'h9);
   wire m_sleep    = m_state == M_SLEEP;

   // command decode
   wire is_meas  = pend_cmd == psc_pkg::CMD_MEASURE;
   wire is_nor   = pend_cmd == psc_pkg::CMD_ONDEMAND;
   wire is_cyc   = pend_cmd == psc_pkg::CMD_PERIODIC;
   wire is_cfg   = pend_cmd == psc_pkg::CMD_CONFIG;
   wire is_srst  = pend_cmd == psc_pkg::CMD_SOFT_RESET;
   wire is_frst  = pend_cmd == psc_pkg::CMD_FIFO_RESET;
   wire long_cmd = (cmd_b == psc_pkg::CMD_MEASURE) | (cmd_b == psc_pkg::CMD_CONFIG);
   wire frame_ok = stop_cond & (i_state == I_WR) & (wr_cnt != 2'h0) & (~long_cmd | (wr_cnt == 2'h3));

   // buffer handshake; a full buffer holds off the next periodic measurement
   wire fifo_active = periodic & cfg[psc_pkg::CFG_FIFO_ON];
   wire buf_full    = buf_cnt == 2'h2;
   wire buf_empty   = buf_cnt == 2'h0;
   wire in_ready    = ~buf_full;
   wire room        = ~fifo_active | in_ready;
   wire exec        = m_sleep & pend_valid & (~is_meas | room);
   wire start       = m_sleep & ((exec & is_meas) | (~pend_valid & periodic & cyc_due & room));
   wire meas_end    = (m_state == M_MEAS) & tick & (timer == 14'h0001);
   wire push        = meas_end & fifo_active & in_ready;
   wire rd_pop      = slot_end & (i_state == I_RD) & (rd_seq == 3'h3) & fifo_active & ~buf_empty;
   wire done_clr    = slot_end & (i_state == I_RD) & (rd_seq == 3'h3);
   wire buf_clr     = exec & (is_srst | is_frst);

   // measurement timing and temperature decimation
   // a starting command times itself with its own oversampling byte
   wire [7:0]  osr_use   = (exec & is_meas) ? pend_d0 : osr;
   wire [13:0] meas_load = psc_pkg::MEAS_TICKS[osr_use[psc_pkg::PRESSURE_OVERSAMPLE_CODE_LSB +: 3]]
                         + psc_pkg::MEAS_TICKS[osr_use[psc_pkg::TEMPERATURE_OVERSAMPLE_CODE_LSB +: 3]];
   wire        period_end = periodic & tick & (period <= 14'h0001);
   wire [13:0] cyc_load  = psc_pkg::CYCLE_TICKS[cfg[psc_pkg::CFG_CYCLE_LSB +: 3]];
   wire [7:0]  rate_span = 8'h01 << cfg[psc_pkg::CFG_TRATE_LSB +: 3];
   wire [6:0]  rate_mask = 7'(rate_span - 8'h01);
   wire        temp_due  = ~periodic | ((temp_seq & rate_mask) == 7'h00);
   wire [19:0] sel_press = cfg[psc_pkg::CFG_CALIB] ? cal_press_i : raw_press_i;
   wire [19:0] sel_temp  = cfg[psc_pkg::CFG_CALIB] ? cal_temp_i : raw_temp_i;
   wire [23:0] new_press = {sel_press, 4'h0};

   // status byte and read-out selection
   wire [7:0] status_byte = {m_state == M_MEAS, 1'b0, periodic, 1'b0, cfg[psc_pkg::CFG_CALIB],
                             fifo_active, buf_full, buf_empty};
   wire [2:0]  next_seq = (rd_seq == (fifo_active ? 3'h3 : 3'h6)) ? 3'h1 : 3'(rd_seq + 3'h1);
   wire        head     = rd_pop ? ~rd_ptr : rd_ptr;
   wire [23:0] rd_word  = fifo_active ? buf_mem[head] : ((next_seq > 3'h3) ? temp_word : press_word);
   wire [1:0]  bsel     = (next_seq == 3'h1 || next_seq == 3'h4) ? 2'h2
                        : (next_seq == 3'h2 || next_seq == 3'h5) ? 2'h1 : 2'h0;
   wire [7:0]  next_byte = rd_word[{bsel, 3'h0} +: 8];
   wire        int_event = done_flag | (cfg[psc_pkg::CFG_FULL_IRQ] & fifo_active & buf_full);
   wire        next_int  = cfg[psc_pkg::CFG_INT_LEVEL] ? int_event : ~int_event;

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
         tick_cnt <= 16'h0000;
         int_o    <= 1'b0;
         sda_o    <= 1'b0;
      end
      else
      begin
         scl_sync <= {scl_sync[0], scl_i};
         sda_sync <= {sda_sync[0], sda_i};
         scl_prev <= scl_s;
         sda_prev <= sda_s;
         // restart on start so a measurement lasts whole ticks, never one short
         tick_cnt <= (tick | start) ? 16'h0000 : 16'(tick_cnt + 16'h0001);
         int_o    <= next_int;
         sda_o    <= 1'b0;
      end
   end

   // bus slave: receive shifts on rising scl, drive changes on falling scl
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         i_state  <= I_IDLE;
         bit_cnt  <= 4'h0;
         shreg    <= 8'h00;
         tx       <= 8'h00;
         m_ack    <= 1'b0;
         wr_cnt   <= 2'h0;
         cmd_b    <= 8'h00;
         d0_b     <= 8'h00;
         d1_b     <= 8'h00;
         rd_seq   <= 3'h0;
         sda_oe_o <= 1'b0;
      end
      else if (start_cond)
      begin
         i_state  <= I_ADDR;
         bit_cnt  <= 4'h0;
         wr_cnt   <= 2'h0;
         sda_oe_o <= 1'b0;
      end
      else if (stop_cond)
      begin
         i_state  <= I_IDLE;
         sda_oe_o <= 1'b0;
      end
      else if (scl_rise && i_state != I_IDLE)
      begin
         if (bit_cnt < 4'h8)
            shreg <= {shreg[6:0], sda_s};
         if (bit_cnt == 4'h8)
            m_ack <= ~sda_s;
         bit_cnt <= 4'(bit_cnt + 4'h1);
      end
      else if (scl_fall && i_state != I_IDLE)
      begin
         if (bit_cnt == 4'h8)
         begin
            if (i_state == I_ADDR && !addr_hit)
               i_state <= I_IDLE;
            sda_oe_o <= (i_state == I_WR) | ((i_state == I_ADDR) & addr_hit);
            if (i_state == I_WR)
            begin
               if (wr_cnt == 2'h0)
                  cmd_b <= shreg;
               if (wr_cnt == 2'h1)
                  d0_b <= shreg;
               if (wr_cnt == 2'h2)
                  d1_b <= shreg;
               if (wr_cnt != 2'h3)
                  wr_cnt <= 2'(wr_cnt + 2'h1);
            end
         end
         else if (bit_cnt == 4'h9)
         begin
            bit_cnt <= 4'h0;
            if (i_state == I_ADDR && shreg[0])
            begin
               i_state  <= I_RD;
               rd_seq   <= 3'h0;
               tx       <= status_byte;
               sda_oe_o <= ~status_byte[7];
            end
            else if (i_state == I_ADDR || i_state == I_WR)
            begin
               i_state  <= I_WR;
               sda_oe_o <= 1'b0;
            end
            else if (m_ack)
            begin
               rd_seq   <= next_seq;
               tx       <= next_byte;
               sda_oe_o <= ~next_byte[7];
            end
            else
            begin
               i_state  <= I_IDLE;
               sda_oe_o <= 1'b0;
            end
         end
         else if (i_state == I_RD)
         begin
            tx       <= {tx[6:0], 1'b0};
            sda_oe_o <= ~tx[6];
         end
      end
   end

   // one waiting command; anything arriving while it waits is dropped
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         pend_valid <= 1'b0;
         pend_cmd   <= 8'h00;
         pend_d0    <= 8'h00;
         pend_d1    <= 8'h00;
      end
      else if (exec)
         pend_valid <= 1'b0;
      else if (frame_ok && !pend_valid)
      begin
         pend_valid <= 1'b1;
         pend_cmd   <= cmd_b;
         pend_d0    <= d0_b;
         pend_d1    <= d1_b;
      end
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         cfg      <= psc_pkg::CFG_RESET;
         osr      <= psc_pkg::OSR_RESET;
         periodic <= 1'b0;
      end
      else if (exec)
      begin
         if (is_nor || is_srst)
            periodic <= 1'b0;
         if (is_cyc)
            periodic <= 1'b1;
         if (is_cfg)
            cfg <= {pend_d0, pend_d1} & psc_pkg::CFG_WRITABLE;
         if (is_srst)
            cfg <= psc_pkg::CFG_RESET;
         if (is_srst)
            osr <= psc_pkg::OSR_RESET;
         if (is_meas)
            osr <= pend_d0;
      end
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         m_state    <= M_SLEEP;
         timer      <= 14'h0000;
         period     <= 14'h0000;
         cyc_due    <= 1'b0;
         done_flag  <= 1'b0;
         temp_seq   <= 7'h00;
         press_word <= 24'h000000;
         temp_word  <= 24'h000000;
      end
      else
      begin
         // entering periodic mode counts a full period, not a stale remainder
         if (exec && is_cyc)
            period <= cyc_load;
         else if (periodic && tick)
            period <= period_end ? cyc_load : 14'(period - 14'h0001);
         if (start)
            cyc_due <= 1'b0;
         if (period_end || (exec && is_cyc))
            cyc_due <= 1'b1;
         if (done_clr)
            done_flag <= 1'b0;
         if (start)
         begin
            m_state   <= M_MEAS;
            timer     <= meas_load;
            done_flag <= 1'b0;
         end
         else if (m_state == M_MEAS && tick)
            timer <= 14'(timer - 14'h0001);
         if (meas_end)
         begin
            m_state    <= M_SLEEP;
            done_flag  <= 1'b1;
            press_word <= new_press;
            temp_seq   <= 7'(temp_seq + 7'h01);
            if (temp_due)
               temp_word <= {sel_temp, 4'h0};
         end
         if (exec && is_srst)
            done_flag <= 1'b0;
      end
   end

   // two-entry result buffer
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         wr_ptr  <= 1'b0;
         rd_ptr  <= 1'b0;
         buf_cnt <= 2'h0;
      end
      else if (buf_clr)
      begin
         wr_ptr  <= 1'b0;
         rd_ptr  <= 1'b0;
         buf_cnt <= 2'h0;
      end
      else
      begin
         if (push)
            wr_ptr <= ~wr_ptr;
         if (rd_pop)
            rd_ptr <= ~rd_ptr;
         buf_cnt <= 2'(buf_cnt + {1'b0, push} - {1'b0, rd_pop});
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (push)
         buf_mem[wr_ptr] <= new_press;
   end

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);

   sequence meas_begin;
      start && cfg[psc_pkg::CFG_INT_LEVEL] && !fifo_active;
   endsequence
   sequence meas_finish;
      meas_end && cfg[psc_pkg::CFG_INT_LEVEL];
   endsequence

   done_low_a: assert property (meas_begin |-> ##2 !int_o)
      else $error("done pin not inactive after start");
   done_high_a: assert property (meas_finish |-> ##2 int_o)
      else $error("done pin not active after measurement");
   read_clear_a: assert property (done_clr && !meas_end && !start |=> !done_flag)
      else $error("done flag survives data read");
   sleep_after_a: assert property (meas_end |=> m_sleep ##1 (m_sleep || $past(start)))
      else $error("no sleep after measurement");
   meas_len_a: assert property (start |=> (m_state == M_MEAS) [*8])
      else $error("measurement shorter than least duration");
   held_cmd_a: assert property (frame_ok && pend_valid && !exec |=> pend_cmd == $past(pend_cmd))
      else $error("waiting command overwritten");
   status_first_a: assert property (slot_end && i_state == I_ADDR && shreg[0]
                                    |=> rd_seq == 3'h0 && tx == $past(status_byte))
      else $error("read does not start with status");
   busy_bit_a: assert property (start |=> status_byte[psc_pkg::ST_BUSY] ##1 status_byte[psc_pkg::ST_BUSY])
      else $error("busy bit low during measurement");
   cfg_mask_a: assert property (exec && is_cfg |=> (cfg & ~psc_pkg::CFG_WRITABLE) == 16'h0000)
      else $error("reserved config bits stored");
   fifo_stall_a: assert property (fifo_active && buf_full && m_sleep |-> !start)
      else $error("measurement started into full buffer");
endmodule

// ===== bench/psc_host.sv
`timescale 1ns/100ps
module psc_host (
   input  wire logic clk_sys_i,
   input  wire logic sda_oe_i,
   output logic      scl_o,
   output logic      sda_o
);
   logic pull_low;
   // pulled-up bus: whichever party pulls low wins
   assign sda_o = ~(pull_low | sda_oe_i);
   initial
   begin
      scl_o = 1'h1;
      pull_low = 1'h0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask
   // data moves only in the low half of scl, sampled mid high
   task automatic bit_io(input logic tx, output logic rx);
      wait_clk(2);
      pull_low = ~tx;
      wait_clk(2);
      scl_o = 1'h1;
      wait_clk(2);
      rx = sda_o;
      wait_clk(2);
      scl_o = 1'h0;
   endtask
   task automatic byte_io(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx, output logic ack_rx);
      for (int i = 7; i >= 0; i--)
         bit_io(tx[i], rx[i]);
      bit_io(ack_tx, ack_rx);
   endtask
   task automatic start_frame(input logic rd, output logic nack);
      logic [7:0] unused;
      wait_clk(4);
      pull_low = 1'h1;
      wait_clk(4);
      scl_o = 1'h0;
      byte_io({psc_pkg::SLAVE_ADDR, rd}, 1'h1, unused, nack);
   endtask
   task automatic stop_frame;
      wait_clk(2);
      pull_low = 1'h1;
      wait_clk(2);
      scl_o = 1'h1;
      wait_clk(4);
      pull_low = 1'h0;
      wait_clk(4);
   endtask
   // command byte, then both data bytes when the command takes them
   task automatic write_frame(input logic [7:0] cmd, input logic [7:0] d0, input logic [7:0] d1,
                              input int n, output logic nack);
      logic [7:0] unused;
      logic       one_nack;
      start_frame(1'h0, nack);
      byte_io(cmd, 1'h1, unused, one_nack);
      nack = nack | one_nack;
      if (n > 1)
      begin
         byte_io(d0, 1'h1, unused, one_nack);
         nack = nack | one_nack;
         byte_io(d1, 1'h1, unused, one_nack);
         nack = nack | one_nack;
      end
      stop_frame();
   endtask
   // last byte is answered with a nack so the slave lets go
   task automatic read_frame(input int n, output logic [55:0] rx, output logic nack);
      logic unused_ack;
      rx = 56'h0;
      start_frame(1'h1, nack);
      for (int i = 0; i < n; i++)
         byte_io(8'hFF, i == n - 1, rx[55 - 8 * i -: 8], unused_ack);
      stop_frame();
   endtask
endmodule

// ===== bench/pressure_sensor_command_control_bench.sv
`timescale 1ns/100ps
module pressure_sensor_command_control_bench;
   localparam int          TICK  = 10;
   localparam logic [19:0] CAL_P = 20'hABCDE;
   localparam logic [19:0] RAW_P = 20'h12345;
   localparam logic [19:0] CAL_T = 20'h56AA0;
   localparam logic [19:0] RAW_T = 20'h0F0F1;
   logic        clk_sys_i = 1'h0;
   logic        nrst_i    = 1'h0;
   logic        scl;
   logic        sda;
   logic        sda_o;
   logic        sda_oe_o;
   logic        int_o;
   logic [55:0] rd;
   int          bad_count   = 0;
   int          comparisons = 0;
   int          cyc         = 0;
   int          t0;
   always #10 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) cyc <= cyc + 1;
   psc_core #(.TICK_CYCLES(TICK)) psc_core_inst (
      .clk_sys_i   (clk_sys_i),
      .nrst_i      (nrst_i),
      .scl_i       (scl),
      .sda_i       (sda),
      .sda_o       (sda_o),
      .sda_oe_o    (sda_oe_o),
      .int_o       (int_o),
      .raw_press_i (RAW_P),
      .cal_press_i (CAL_P),
      .raw_temp_i  (RAW_T),
      .cal_temp_i  (CAL_T)
   );
   psc_host psc_host_inst (
      .clk_sys_i (clk_sys_i),
      .sda_oe_i  (sda_oe_o),
      .scl_o     (scl),
      .sda_o     (sda)
   );
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check_val(input string what, input logic [55:0] exp, input logic [55:0] got);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic check_pin(input string what, input logic exp);
      check_val(what, {55'h0, exp}, {55'h0, int_o});
   endtask
   // latency of the pin path allows a few cycles beyond the nominal count
   task automatic check_time(input string what, input int exp, input int got);
      comparisons++;
      if (got < exp || got > exp + 20)
      begin
         bad_count++;
         $display("wrong value %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   task automatic send(input logic [7:0] cmd, input logic [7:0] d0, input logic [7:0] d1, input int n);
      logic nack;
      psc_host_inst.write_frame(cmd, d0, d1, n, nack);
      check_val("write ack", 56'h0, {55'h0, nack});
   endtask
   task automatic fetch(input int n, input logic [7:0] st, input logic [7:0] st_mask,
                        input logic [47:0] data, input string what);
      logic nack;
      psc_host_inst.read_frame(n, rd, nack);
      check_val(what, {st, data}, rd & {st_mask, 48'hFFFFFFFFFFFF});
   endtask
   task automatic wait_int(input logic lvl);
      for (int i = 0; i < 20000 && int_o !== lvl; i++)
         @(negedge clk_sys_i);
   endtask
   initial
   begin
      repeat (4) @(negedge clk_sys_i);
      nrst_i = 1'h1;
      repeat (5) @(negedge clk_sys_i);
      check_pin("done pin idle", 1'h0);
      fetch(1, 8'h09, 8'hFF, 48'h0, "idle status");
      send(psc_pkg::CMD_MEASURE, 8'h77, 8'h00, 3);
      t0 = cyc;
      wait_int(1'h1);
      check_pin("done pin at end", 1'h1);
      check_time("short measure", 2 * psc_pkg::MEAS_TICKS[7] * TICK, cyc - t0);
      fetch(7, 8'h09, 8'hFF, {CAL_P, 4'h0, CAL_T, 4'h0}, "calibrated read");
      check_pin("done pin after read", 1'h0);
      // calibration bit clear in the config word, so the next read returns raw data
      send(psc_pkg::CMD_CONFIG, 8'h90, 8'h00, 3);
      send(psc_pkg::CMD_MEASURE, 8'h77, 8'h00, 3);
      wait_int(1'h1);
      fetch(7, 8'h01, 8'hFF, {RAW_P, 4'h0, RAW_T, 4'h0}, "raw read");
      send(psc_pkg::CMD_CONFIG, 8'h10, 8'h00, 3);
      psc_host_inst.wait_clk(10);
      check_pin("active low idle", 1'h1);
      send(psc_pkg::CMD_MEASURE, 8'h77, 8'h00, 3);
      wait_int(1'h0);
      check_pin("active low done", 1'h0);
      send(psc_pkg::CMD_SOFT_RESET, 8'h00, 8'h00, 1);
      psc_host_inst.wait_clk(10);
      check_pin("done after soft reset", 1'h0);
      fetch(1, 8'h09, 8'hFF, 48'h0, "soft reset status");
      // leave done set, then a long measurement must clear it
      send(psc_pkg::CMD_MEASURE, 8'h77, 8'h00, 3);
      wait_int(1'h1);
      send(psc_pkg::CMD_MEASURE, 8'h00, 8'h00, 3);
      t0 = cyc;
      psc_host_inst.wait_clk(20);
      check_pin("done at start", 1'h0);
      fetch(1, 8'h89, 8'hFF, 48'h0, "busy status");
      send(psc_pkg::CMD_PERIODIC, 8'h00, 8'h00, 1);
      send(psc_pkg::CMD_ONDEMAND, 8'h00, 8'h00, 1);
      fetch(1, 8'h80, 8'hE0, 48'h0, "switch held");
      wait_int(1'h1);
      check_time("long measure", 2 * psc_pkg::MEAS_TICKS[0] * TICK, cyc - t0);
      fetch(1, 8'h20, 8'h60, 48'h0, "periodic mode");
      send(psc_pkg::CMD_SOFT_RESET, 8'h00, 8'h00, 1);
      // soft reset waits for the running measurement
      psc_host_inst.wait_clk(7000);
      fetch(1, 8'h09, 8'hFF, 48'h0, "back to on-demand");
      send(psc_pkg::CMD_FIFO_RESET, 8'h00, 8'h00, 1);
      fetch(1, 8'h09, 8'hFF, 48'h0, "fifo reset status");
      // fifo on, 50 tick cycle: one word at once, a second only a period later
      send(psc_pkg::CMD_CONFIG, 8'hD8, 8'h00, 3);
      send(psc_pkg::CMD_PERIODIC, 8'h00, 8'h00, 1);
      psc_host_inst.wait_clk(300);
      fetch(1, 8'h2C, 8'hFF, 48'h0, "one word buffered");
      psc_host_inst.wait_clk(300);
      check_pin("full buffer pin", 1'h1);
      fetch(1, 8'h2E, 8'hFF, 48'h0, "buffer full");
      fetch(4, 8'h2E, 8'hFF, {CAL_P, 4'h0, 24'h0}, "buffered pressure");
      complete_run();
   end
   initial
   begin
      #1200000;
      bad_count++;
      complete_run();
   end
endmodule
